// [common/sci_regs.svh]
// Purpose: Offsets, field positions and reset values of the core access bridge.
// Assumes: Host offsets are byte addresses on a 10-bit host address.
// Notes:   Included by its bare name; definitions only.
// How it works
// RULE1: Core registers sit at indirect addresses 0 to 0FFFh, via data and command.
// RULE2: Process RAM is reachable through the same pair, starting at 1000h.
// RULE3: Host starts a core read with one command write: pending, target, read, size.
// RULE4: Pending clears when read data is ready; host reads data only afterwards.
// RULE5: Accessed value is right-justified in the data register.
// RULE6: A core read rewrites every byte of the data register.
// RULE7: Host loads data first, then writes command with pending set and read cleared.
// RULE8: End of a core write shows as pending cleared.
// RULE9: Host waits the read-after-write gaps at the marked points.
// RULE10: Process RAM read data passes through a 16 by 32-bit FIFO.
// RULE11: FIFO answers at its base and seven following word aliases.
// RULE12: In FIFO direct select mode every read goes to the FIFO.
// RULE13: Host writes span, then read control with the active bit set.
// RULE14: Host keeps the whole transfer inside 1000h to 1FFFh.
// RULE15: Read control shows data present and a count of safe FIFO reads.
// RULE16: Active self-clears after the final FIFO read, which takes all four bytes.
// RULE17: Remaining length and current address advance as words enter the FIFO.
// RULE18: First word marks lanes valid from the start address low bits upward.
// RULE19: Setting the cancel bit stops a running process RAM read.
// RULE20: Host issues no new command while pending or active is still set.
`ifndef SCI_REGS_SVH
`define SCI_REGS_SVH

`define SCI_OFF_FIFO_TOP  5'h00
`define SCI_OFF_DATA      10'h300
`define SCI_OFF_CMD       10'h304
`define SCI_OFF_SPAN      10'h308
`define SCI_OFF_RCTL      10'h30C

`define SCI_CMD_PEND_BIT  31
`define SCI_CMD_DIR_BIT   30
`define SCI_CMD_SIZE_LSB  16
`define SCI_SPAN_LEN_LSB  16
`define SCI_RCTL_ACT_BIT  31
`define SCI_RCTL_CAN_BIT  30
`define SCI_RCTL_CNT_LSB  8
`define SCI_RCTL_PRS_BIT  0

`define SCI_RAM_BASE      16'h1000
`define SCI_FIFO_DEPTH    16
`define SCI_RST_WORD      32'h0000_0000

`endif

// [common/sci_pkg.sv]
// Purpose: Types shared by the core access bridge.
// Assumes: Nothing beyond the constants header.
// Notes:   Used with explicit sci_pkg:: scoping only.
`default_nettype none
package sci_pkg;
    // Owner of the single core access port
    typedef enum logic [1:0] {ARB_IDLE, ARB_CSR, ARB_RAM} sci_arb_t;
endpackage
`default_nettype wire

// [verilog/sci_fifo.sv]
// Purpose: Show-ahead FIFO with valid/ready on both sides.
// Assumes: Flush clears content in one cycle.
// Notes:   Full and empty come straight from the occupancy count.
`default_nettype none
module sci_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic             push;
    logic             pop;

    // Handshakes see the honest fill level
    assign in_ready  = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rptr_reg];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    // Storage needs no reset; pointers guard it
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count    <= '0;
        end else if (flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count    <= '0;
        end else begin
            wptr_reg <= wptr_reg + AW'(push);
            rptr_reg <= rptr_reg + AW'(pop);
            count    <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [verilog/sci_lanes.sv]
// Purpose: Byte lane mask from a lowest and a highest valid lane.
// Assumes: lo is not above hi.
// Notes:   Pure combinational.
`default_nettype none
module sci_lanes (
    input  wire logic [1:0] lo,
    input  wire logic [1:0] hi,
    output logic [3:0]      mask
);
    // One bit per lane inside the range
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            mask[i] = (2'(i) >= lo) && (2'(i) <= hi);
        end
    end
endmodule
`default_nettype wire

// [verilog/sci_bridge.sv]
// Purpose: Host access to core registers and streamed process RAM reads.
// Assumes: Core port answers one request at a time with a one-cycle ack.
// Notes:   Host port answers every access one cycle later with host_ack.
`include "sci_regs.svh"
`default_nettype none
module sci_bridge (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        host_sel,
    input  wire logic        host_we,
    input  wire logic [9:0]  host_addr,
    input  wire logic [31:0] host_wdata,
    input  wire logic        fifo_direct_sel,
    output logic [31:0]      host_rdata,
    output logic             host_ack,
    output logic             core_req,
    output logic             core_we,
    output logic             core_ram_sel,
    output logic [15:0]      core_addr,
    output logic [2:0]       core_size,
    output logic [31:0]      core_wdata,
    input  wire logic        core_ack,
    input  wire logic [31:0] core_rdata,
    output logic [3:0]       read_lane_valid
);
    sci_pkg::sci_arb_t arb_reg;
    logic [31:0] data_reg;
    logic        pend_reg;
    logic        dir_reg;
    logic [2:0]  size_reg;
    logic [15:0] target_reg;
    logic [15:0] span_addr_reg;
    logic [15:0] span_len_reg;
    logic        active_reg;
    logic        first_reg;
    logic [15:0] words_left_reg;
    logic [1:0]  start_lane_reg;
    logic [1:0]  end_lane_reg;
    logic [31:0] rd_val;
    logic [4:0]  fifo_count;
    logic [31:0] fifo_data;
    logic        fifo_out_valid;
    logic        fifo_in_ready;
    logic [3:0]  lane_mask;
    logic        wr_any;
    logic        rd_sel;
    logic        rd_fifo;
    logic        pop;
    logic        wr_cmd;
    logic        start_rd;
    logic        cancel_rd;
    logic        csr_done;
    logic        ram_done;
    logic [2:0]  lane_room;
    logic [15:0] take;

    // Size field counts bytes; the mask keeps the value right-justified
    function automatic logic [31:0] size_mask(input logic [2:0] sz);
        case (sz)
            3'h1:    size_mask = 32'h0000_00FF;
            3'h2:    size_mask = 32'h0000_FFFF;
            default: size_mask = 32'hFFFF_FFFF;
        endcase
    endfunction

    // Host decode
    assign wr_any    = host_sel && host_we;
    assign rd_sel    = host_sel && !host_we;
    // RULE11: eight word aliases
    // RULE12: direct select ignores address
    assign rd_fifo   = rd_sel && (fifo_direct_sel || host_addr[9:5] == `SCI_OFF_FIFO_TOP);
    assign pop       = rd_fifo && fifo_out_valid;
    assign wr_cmd    = wr_any && host_addr == `SCI_OFF_CMD && !pend_reg;
    assign start_rd  = wr_any && host_addr == `SCI_OFF_RCTL && !active_reg
                       && host_wdata[`SCI_RCTL_ACT_BIT] && span_len_reg != '0;
    assign cancel_rd = wr_any && host_addr == `SCI_OFF_RCTL
                       && host_wdata[`SCI_RCTL_CAN_BIT];
    assign csr_done  = arb_reg == sci_pkg::ARB_CSR && core_ack;
    assign ram_done  = arb_reg == sci_pkg::ARB_RAM && core_ack;

    // Bytes the next word carries: rest of the word, capped by what remains
    assign lane_room = 3'h4 - {1'b0, span_addr_reg[1:0]};
    assign take      = (span_len_reg < {13'h0, lane_room}) ? span_len_reg
                                                            : {13'h0, lane_room};

    // Command and data registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_reg   <= `SCI_RST_WORD;
            pend_reg   <= 1'b0;
            dir_reg    <= 1'b0;
            size_reg   <= '0;
            target_reg <= '0;
        end else begin
            if (wr_any && host_addr == `SCI_OFF_DATA) begin
                data_reg <= host_wdata;
            end
            // RULE5: right-justified value
            // RULE6: all bytes rewritten
            if (csr_done && dir_reg) begin
                data_reg <= core_rdata & size_mask(size_reg);
            end
            if (wr_cmd) begin
                pend_reg   <= host_wdata[`SCI_CMD_PEND_BIT];
                dir_reg    <= host_wdata[`SCI_CMD_DIR_BIT];
                size_reg   <= host_wdata[`SCI_CMD_SIZE_LSB +: 3];
                target_reg <= host_wdata[15:0];
            end
            // RULE4: ready data clears pending
            // RULE8: write done clears pending
            if (csr_done) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // Core port arbiter; a pending register command goes first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arb_reg      <= sci_pkg::ARB_IDLE;
            core_req     <= 1'b0;
            core_we      <= 1'b0;
            core_ram_sel <= 1'b0;
            core_addr    <= '0;
            core_size    <= '0;
            core_wdata   <= `SCI_RST_WORD;
        end else begin
            case (arb_reg)
                sci_pkg::ARB_IDLE: begin
                    if (pend_reg) begin
                        arb_reg      <= sci_pkg::ARB_CSR;
                        core_req     <= 1'b1;
                        core_we      <= !dir_reg;
                        // RULE1: low space is core registers
                        // RULE2: upper space is process RAM
                        core_ram_sel <= target_reg >= `SCI_RAM_BASE;
                        core_addr    <= target_reg;
                        core_size    <= size_reg;
                        core_wdata   <= data_reg & size_mask(size_reg);
                    end else if (active_reg && !cancel_rd && span_len_reg != '0
                                 && fifo_in_ready) begin
                        // Whole aligned word; one request in flight keeps room honest
                        arb_reg      <= sci_pkg::ARB_RAM;
                        core_req     <= 1'b1;
                        core_we      <= 1'b0;
                        core_ram_sel <= 1'b1;
                        core_addr    <= {span_addr_reg[15:2], 2'b00};
                        core_size    <= 3'h4;
                    end
                end
                sci_pkg::ARB_CSR, sci_pkg::ARB_RAM: begin
                    if (core_ack) begin
                        arb_reg  <= sci_pkg::ARB_IDLE;
                        core_req <= 1'b0;
                    end
                end
                default: begin
                    arb_reg  <= sci_pkg::ARB_IDLE;
                    core_req <= 1'b0;
                end
            endcase
        end
    end

    // Read span and transfer state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            span_addr_reg  <= '0;
            span_len_reg   <= '0;
            active_reg     <= 1'b0;
            first_reg      <= 1'b0;
            words_left_reg <= '0;
            start_lane_reg <= '0;
            end_lane_reg   <= '0;
        end else begin
            if (wr_any && host_addr == `SCI_OFF_SPAN && !active_reg) begin
                span_addr_reg <= host_wdata[15:0];
                span_len_reg  <= host_wdata[`SCI_SPAN_LEN_LSB +: 16];
            end
            if (start_rd) begin
                active_reg     <= 1'b1;
                first_reg      <= 1'b1;
                words_left_reg <= 16'((17'(span_len_reg) + 17'(span_addr_reg[1:0])
                                       + 17'h3) >> 2);
                start_lane_reg <= span_addr_reg[1:0];
                end_lane_reg   <= 2'(span_addr_reg + span_len_reg - 16'h1);
            end
            // RULE17: progress shown
            if (ram_done && active_reg) begin
                span_addr_reg <= span_addr_reg + take;
                span_len_reg  <= span_len_reg - take;
            end
            if (pop && active_reg) begin
                first_reg      <= 1'b0;
                words_left_reg <= words_left_reg - 16'h1;
                // RULE16: final read self-clears
                if (words_left_reg == 16'h1) begin
                    active_reg <= 1'b0;
                end
            end
            // RULE19: cancel stops transfer
            if (cancel_rd) begin
                active_reg <= 1'b0;
            end
        end
    end

    // RULE10: sixteen by thirty-two buffer
    sci_fifo #(
        .WIDTH (32),
        .DEPTH (`SCI_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (cancel_rd),
        .in_valid  (ram_done && active_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (core_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (rd_fifo),
        .out_data  (fifo_data),
        .count     (fifo_count)
    );

    // RULE18: first word lanes from start
    sci_lanes u_lanes (
        .lo   (first_reg ? start_lane_reg : 2'b00),
        .hi   (words_left_reg == 16'h1 ? end_lane_reg : 2'b11),
        .mask (lane_mask)
    );

    // Read-back mux; the final word counts as four bytes whatever the mask says
    always_comb begin
        rd_val = `SCI_RST_WORD;
        if (rd_fifo) begin
            rd_val = fifo_out_valid ? fifo_data : `SCI_RST_WORD;
        end else begin
            case (host_addr)
                `SCI_OFF_DATA: rd_val = data_reg;
                `SCI_OFF_CMD: begin
                    rd_val[`SCI_CMD_PEND_BIT]          = pend_reg;
                    rd_val[`SCI_CMD_DIR_BIT]           = dir_reg;
                    rd_val[`SCI_CMD_SIZE_LSB +: 3]     = size_reg;
                    rd_val[15:0]                       = target_reg;
                end
                `SCI_OFF_SPAN: rd_val = {span_len_reg, span_addr_reg};
                `SCI_OFF_RCTL: begin
                    rd_val[`SCI_RCTL_ACT_BIT]          = active_reg;
                    // RULE15: present flag and count
                    rd_val[`SCI_RCTL_CNT_LSB +: 5]     = fifo_count;
                    rd_val[`SCI_RCTL_PRS_BIT]          = fifo_out_valid;
                end
                default: rd_val = `SCI_RST_WORD;
            endcase
        end
    end

    // Host answer and lane report, all registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            host_rdata      <= `SCI_RST_WORD;
            host_ack        <= 1'b0;
            read_lane_valid <= 4'h0;
        end else begin
            host_ack <= host_sel;
            if (rd_sel) begin
                host_rdata <= rd_val;
            end
            if (pop) begin
                read_lane_valid <= lane_mask;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_cancel;
        cancel_rd;
    endsequence
    sequence s_drained;
        !active_reg && fifo_count == 5'h0;
    endsequence

    property p_space;
        core_req |-> core_ram_sel == (core_addr >= `SCI_RAM_BASE);
    endproperty
    a_space: assert property (p_space) else $error("core space select wrong"); // RULE2

    property p_pend;
        csr_done |=> !pend_reg;
    endproperty
    a_pend: assert property (p_pend) else $error("pending not cleared"); // RULE4

    property p_rewrite;
        csr_done && dir_reg |=> data_reg == ($past(core_rdata) & size_mask($past(size_reg)));
    endproperty
    a_rewrite: assert property (p_rewrite) else $error("data not rewritten"); // RULE6

    property p_byte;
        csr_done && dir_reg && size_reg == 3'h1 |=> data_reg[31:8] == 24'h00_0000;
    endproperty
    a_byte: assert property (p_byte) else $error("value not right-justified"); // RULE5

    property p_depth;
        fifo_count <= 5'h10 && (fifo_count != 5'h10 || !fifo_in_ready);
    endproperty
    a_depth: assert property (p_depth) else $error("fifo over sixteen"); // RULE10

    property p_direct;
        rd_sel && fifo_direct_sel && fifo_out_valid |=> fifo_count == $past(fifo_count) - 5'h1
            || $past(cancel_rd || ram_done);
    endproperty
    a_direct: assert property (p_direct) else $error("direct read missed fifo"); // RULE12

    property p_count;
        rd_sel && !fifo_direct_sel && host_addr == `SCI_OFF_RCTL
            |=> host_rdata[12:8] == $past(fifo_count) && host_rdata[0] == ($past(fifo_count) != 0);
    endproperty
    a_count: assert property (p_count) else $error("avail count wrong"); // RULE15

    property p_selfclr;
        pop && active_reg && words_left_reg == 16'h1 |=> !active_reg;
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("active did not clear"); // RULE16

    property p_progress;
        ram_done && active_reg |=> span_len_reg == $past(span_len_reg) - $past(take)
            || $past(wr_any);
    endproperty
    a_progress: assert property (p_progress) else $error("length not advanced"); // RULE17

    property p_first;
        pop && first_reg && start_lane_reg == 2'b10 && words_left_reg > 16'h1
            |=> read_lane_valid == 4'hC;
    endproperty
    a_first: assert property (p_first) else $error("first lanes wrong"); // RULE18

    property p_cancel;
        s_cancel |=> s_drained;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel did not stop"); // RULE19
endmodule
`default_nettype wire

// [verification/sci_core_model.sv]
// Purpose: Behavioural core port holding register space and process RAM.
// Assumes: The bridge keeps one request outstanding at a time.
// Notes:   Read values follow the address so that the bench can predict them.
`default_nettype none
module sci_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        slow,
    input  wire logic        core_req,
    input  wire logic        core_we,
    input  wire logic [15:0] core_addr,
    input  wire logic [2:0]  core_size,
    input  wire logic [31:0] core_wdata,
    output logic             core_ack,
    output logic [31:0]      core_rdata,
    output logic [15:0]      last_addr,
    output logic [31:0]      last_wdata,
    output int               n_req
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0]  wait_cnt;
    logic [31:0] word;

    // Value follows the address; narrow reads come back right-justified
    always_comb begin
        word = {core_addr ^ 16'h5a5a, core_addr};
        if (core_size == 3'h1) begin
            word = word & 32'h0000_00ff;
        end else if (core_size == 3'h2) begin
            word = word & 32'h0000_ffff;
        end
    end

    // Answer after one or six cycles; with no request waiting, and on a write ack,
    // the data lines toggle so a stale capture cannot pass by luck
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_ack   <= 1'b0;
            wait_cnt   <= 4'h0;
            core_rdata <= 32'h0000_0000;
            last_addr  <= 16'h0000;
            last_wdata <= 32'h0000_0000;
            n_req      <= 0;
        end else if (core_ack || !core_req) begin
            core_ack   <= 1'b0;
            wait_cnt   <= 4'h0;
            core_rdata <= ~core_rdata;
        end else if (wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
            core_ack   <= 1'b1;
            core_rdata <= core_we ? ~core_rdata : word;
            last_addr  <= core_addr;
            last_wdata <= core_we ? core_wdata : last_wdata;
            n_req      <= n_req + 1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Purpose: Self-checking bench for the core access bridge.
// Assumes: Host port acks one cycle after each strobe.
// Notes:   Every scenario is its own task and judges its own results.
`include "sci_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, rstn, host_sel, host_we, fifo_direct_sel, slow;
    logic [9:0]  host_addr;
    logic [31:0] host_wdata, host_rdata, core_wdata, core_rdata, last_wdata;
    logic        host_ack, core_req, core_we, core_ack, core_ram_sel;
    logic [15:0] core_addr, last_addr;
    logic [2:0]  core_size;
    logic [3:0]  read_lane_valid;
    int          n_req;
    int          n_mismatch = 0;
    int          comparisons = 0;

    sci_bridge i_sci_bridge (.clk(clk), .rstn(rstn), .host_sel(host_sel), .host_we(host_we),
        .host_addr(host_addr), .host_wdata(host_wdata), .fifo_direct_sel(fifo_direct_sel),
        .host_rdata(host_rdata), .host_ack(host_ack), .core_req(core_req), .core_we(core_we),
        .core_ram_sel(core_ram_sel), .core_addr(core_addr), .core_size(core_size),
        .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata),
        .read_lane_valid(read_lane_valid));
    sci_core_model i_sci_core_model (.clk(clk), .rstn(rstn), .slow(slow), .core_req(core_req),
        .core_we(core_we), .core_addr(core_addr), .core_size(core_size),
        .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata),
        .last_addr(last_addr), .last_wdata(last_wdata), .n_req(n_req));

    // Free-running clock
    always #5 clk = ~clk;

    // One comparison, reported at once when it fails
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one host access, always followed by an idle cycle
    task automatic acc(input logic we, input logic [9:0] a, input logic [31:0] d,
                       input logic ds, output logic [31:0] q);
        @(posedge clk);
        host_sel        <= 1'b1;
        host_we         <= we;
        host_addr       <= a;
        host_wdata      <= d;
        fifo_direct_sel <= ds;
        @(posedge clk);
        host_sel        <= 1'b0;
        fifo_direct_sel <= 1'b0;
        #1;
        chk({31'h0000_0000, host_ack}, 32'h0000_0001);
        q = host_rdata;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, 1'b0, q);
    endtask

    // wait for a status field before the next command; bounded
    task automatic poll(input logic [9:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            acc(1'b0, a, 32'h0000_0000, 1'b0, q);
            n++;
        end while ((q & m) !== v && n < 300);
        chk(q & m, v);
    endtask

    // Narrow reads of core registers and a full read of RAM via the command pair
    task automatic t_csr_read;
        logic [2:0]  sz [3] = '{3'h1, 3'h2, 3'h4};
        logic [31:0] mk [3] = '{32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
        logic [15:0] ta [3] = '{16'h0ff0, 16'h0ffe, 16'h1004};
        logic [31:0] q;
        foreach (sz[i]) begin
            wr(`SCI_OFF_DATA, 32'hffff_ffff);
            wr(`SCI_OFF_CMD, {2'b11, 11'h000, sz[i], ta[i]});
            poll(`SCI_OFF_CMD, 32'h8000_0000, 32'h0000_0000);
            acc(1'b0, `SCI_OFF_DATA, 32'h0000_0000, 1'b0, q);
            chk(q, {ta[i] ^ 16'h5a5a, ta[i]} & mk[i]);
            chk({16'h0000, last_addr}, {16'h0000, ta[i]});
            chk({31'h0000_0000, core_ram_sel}, {31'h0000_0000, ta[i] >= 16'h1000});
        end
        $display("test csr read done");
    endtask

    // Write with a slow core; a second command while pending is ignored
    task automatic t_csr_write;
        int n0;
        @(posedge clk) slow <= 1'b1;
        n0 = n_req;
        // data first, then the write command
        wr(`SCI_OFF_DATA, 32'h1122_3344);
        wr(`SCI_OFF_CMD, {2'b10, 11'h000, 3'h2, 16'h0ffe});
        wr(`SCI_OFF_CMD, {2'b10, 11'h000, 3'h4, 16'h0010});
        poll(`SCI_OFF_CMD, 32'h8000_0000, 32'h0000_0000);
        chk(last_wdata, 32'h0000_3344);
        chk({16'h0000, last_addr}, 32'h0000_0ffe);
        chk(32'(n_req - n0), 32'h0000_0001);
        @(posedge clk) slow <= 1'b0;
        $display("test csr write done");
    endtask

    // Unaligned three-word stream read through aliases and direct select
    task automatic t_ram_read;
        logic [9:0]  pa [3] = '{10'h000, `SCI_OFF_RCTL, 10'h01c};
        logic [3:0]  ln [3] = '{4'he, 4'hf, 4'h7};
        logic [15:0] wa;
        logic [31:0] q;
        // span then start, inside the RAM window
        wr(`SCI_OFF_SPAN, 32'h000a_1001);
        wr(`SCI_OFF_RCTL, 32'h8000_0000);
        poll(`SCI_OFF_RCTL, 32'h0000_1f01, 32'h0000_0301);
        for (int k = 0; k < 3; k++) begin
            wa = 16'(16'h1000 + 4 * k);
            acc(1'b0, pa[k], 32'h0000_0000, k == 1, q);
            chk(q, {wa ^ 16'h5a5a, wa});
            chk({28'h000_0000, read_lane_valid}, {28'h000_0000, ln[k]});
        end
        acc(1'b0, `SCI_OFF_RCTL, 32'h0000_0000, 1'b0, q);
        chk(q & 32'h8000_0001, 32'h0000_0000);
        acc(1'b0, `SCI_OFF_SPAN, 32'h0000_0000, 1'b0, q);
        chk(q, 32'h0000_100b);
        acc(1'b0, 10'h004, 32'h0000_0000, 1'b0, q);
        chk(q, 32'h0000_0000);
        $display("test ram read done");
    endtask

    // Twenty words through the sixteen-deep buffer with the host stalling
    task automatic t_fill;
        logic [15:0] wa;
        logic [31:0] q;
        @(posedge clk) slow <= 1'b1;
        wr(`SCI_OFF_SPAN, 32'h0050_1000);
        wr(`SCI_OFF_RCTL, 32'h8000_0000);
        poll(`SCI_OFF_RCTL, 32'h0000_1f01, 32'h0000_1001);
        repeat (20) @(posedge clk);
        acc(1'b0, `SCI_OFF_RCTL, 32'h0000_0000, 1'b0, q);
        chk(q & 32'h8000_1f01, 32'h8000_1001);
        @(posedge clk) slow <= 1'b0;
        for (int k = 0; k < 20; k++) begin
            wa = 16'(16'h1000 + 4 * k);
            poll(`SCI_OFF_RCTL, 32'h0000_0001, 32'h0000_0001);
            acc(1'b0, 10'((k % 8) * 4), 32'h0000_0000, 1'b0, q);
            chk(q, {wa ^ 16'h5a5a, wa});
        end
        acc(1'b0, `SCI_OFF_RCTL, 32'h0000_0000, 1'b0, q);
        chk(q & 32'h8000_1f01, 32'h0000_0000);
        $display("test fill done");
    endtask

    // Cancel in mid-stream, then an unmapped read
    task automatic t_cancel;
        logic [31:0] q;
        wr(`SCI_OFF_SPAN, 32'h0040_1100);
        wr(`SCI_OFF_RCTL, 32'h8000_0000);
        poll(`SCI_OFF_RCTL, 32'h0000_0001, 32'h0000_0001);
        wr(`SCI_OFF_RCTL, 32'h4000_0000);
        repeat (10) @(posedge clk);
        acc(1'b0, `SCI_OFF_RCTL, 32'h0000_0000, 1'b0, q);
        chk(q & 32'hc000_1f01, 32'h0000_0000);
        acc(1'b0, 10'h000, 32'h0000_0000, 1'b0, q);
        chk(q, 32'h0000_0000);
        acc(1'b0, 10'h200, 32'h0000_0000, 1'b0, q);
        chk(q, 32'h0000_0000);
        $display("test cancel done");
    endtask

    // Counts, verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Reset for five cycles, then the scenarios in turn
    initial begin
        clk             = 1'b0;
        rstn            = 1'b0;
        host_sel        = 1'b0;
        host_we         = 1'b0;
        host_addr       = 10'h000;
        host_wdata      = 32'h0000_0000;
        fifo_direct_sel = 1'b0;
        slow            = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_csr_read;
        t_csr_write;
        t_ram_read;
        t_fill;
        t_cancel;
        tally_and_finish;
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #200_000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
